// ### hdl/lcdsl_device.sv
// Device end: serial slave, command decoder and 40x4 display RAM.
`timescale 1ns/1ps

module lcdsl_device (
    input  wire logic                    rst_i,
    input  wire logic                    addr_lsb_strap_i,
    input  wire logic                    chip_subaddr_bit0_i,
    input  wire logic                    chip_subaddr_bit1_i,
    input  wire logic                    chip_subaddr_bit2_i,
    output logic [159:0]                 segment_outputs_o,
    output lcdsl_pkg::lcdsl_mode_t       lcd_mode_o,
    output logic [2:0]                   blink_o,
    output logic                         sleep_o,
    output logic                         selected_o,
    output logic [5:0]                   data_ptr_o,
    output logic [2:0]                   subaddr_o,
    lcdsl_if.dev                         link
);
    import lcdsl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]                          strap_meta;
        logic [3:0]                          strap_sync;
        logic                                sda_p;
        lcdsl_phase_t                        phase;
        logic [3:0]                          bit_cnt;
        logic [6:0]                          shreg;
        logic                                ack;
        logic [5:0]                          ptr;
        logic [2:0]                          sub;
        lcdsl_mode_t                         mode;
        logic [2:0]                          blink;
        logic                                sleep;
        logic                                sel;
        logic [RAM_WORDS-1:0][COM_LINES-1:0] ram;
    } lcdsl_dev_state_t;

    typedef struct packed {
        logic sda_n;
        logic sda_oe_n;
    } lcdsl_dev_edge_t;

    lcdsl_dev_state_t q, d;
    lcdsl_dev_edge_t  e_q, e_d;

    logic       start;
    logic [7:0] rx_byte;
    logic       sub_hit;
    logic [4:0] slot;
    logic [6:0] waddr;
    logic [6:0] nxt;
    logic [5:0] step;

    // ------------------------------------------------------------------
    // Fill order: bit k of a byte, MSB first, lands at {word offset, common}
    // ------------------------------------------------------------------
    function automatic logic [4:0] fill_slot(input lcdsl_mode_t m, input int k);
        unique case (m)
            MODE_STATIC: fill_slot = {3'(k), 2'h0};
            MODE_DUAL:   fill_slot = {3'(k / 2), 2'(k % 2)};
            MODE_TRI:    fill_slot = {3'(k / 3), 2'(k % 3)};
            MODE_QUAD:   fill_slot = {3'(k / 4), 2'(k % 4)};
        endcase
    endfunction : fill_slot

    // ------------------------------------------------------------------
    // Rising-edge logic: straps, byte assembly, decode and RAM writes
    // ------------------------------------------------------------------
    always_comb begin
        d            = q;
        slot         = 5'h00;
        waddr        = 7'h00;
        nxt          = 7'h00;
        step         = 6'h00;
        d.strap_meta = {addr_lsb_strap_i, chip_subaddr_bit2_i,
                        chip_subaddr_bit1_i, chip_subaddr_bit0_i};
        d.strap_sync = q.strap_meta;
        d.sda_p      = link.sda;
        // Data sampled high at the last rise but low at the following fall
        // can only be a START; this edge already carries the first bit.
        start        = q.sda_p && !e_q.sda_n;
        rx_byte      = {q.shreg, link.sda};
        sub_hit      = (q.sub == q.strap_sync[2:0]);
        if (start) begin
            d.phase   = PH_ADDR;
            d.bit_cnt = 4'h1;
            d.shreg   = {6'h00, link.sda};
            d.ack     = 1'b0;
        end else if (q.phase != PH_IDLE && q.phase != PH_SKIP) begin
            if (q.bit_cnt == 4'h8) begin
                d.bit_cnt = 4'h0;
                d.ack     = 1'b0;
            end else begin
                d.bit_cnt = q.bit_cnt + 4'h1;
                d.shreg   = rx_byte[6:0];
                if (q.bit_cnt == 4'h7) begin
                    unique case (q.phase)
                        PH_ADDR: begin
                            // Write transfers only; a read address is not ours.
                            if (rx_byte[7:1] == {ADDR_HI, q.strap_sync[3]}
                                    && !rx_byte[0]) begin
                                d.ack   = 1'b1;
                                d.phase = PH_CMD;
                            end else begin
                                d.phase = PH_SKIP;
                            end
                        end
                        PH_CMD: begin
                            d.ack = 1'b1;
                            if (cmd_is(rx_byte, CMD_PTR_MASK, CMD_PTR_CODE)) begin
                                d.ptr = rx_byte[5:0];
                            end else if (cmd_is(rx_byte, CMD_GRP_MASK, CMD_MODE_CODE)) begin
                                d.mode = lcdsl_mode_t'(rx_byte[1:0]);
                            end else if (cmd_is(rx_byte, CMD_GRP_MASK, CMD_SLP_CODE)) begin
                                d.sleep = rx_byte[0];
                            end else if (cmd_is(rx_byte, CMD_GRP_MASK, CMD_SEL_CODE)) begin
                                d.sub = rx_byte[2:0];
                            end else if (cmd_is(rx_byte, CMD_GRP_MASK, CMD_BLK_CODE)) begin
                                d.blink = rx_byte[2:0];
                            end
                            if (!rx_byte[CONT_BIT]) begin
                                d.phase = PH_DATA;
                            end
                        end
                        PH_DATA: begin
                            d.ack = sub_hit;
                            for (int k = 0; k < 8; k++) begin
                                slot  = fill_slot(q.mode, k);
                                waddr = 7'(q.ptr) + 7'(slot[4:2]);
                                // Bits past the last word are dropped.
                                if (sub_hit && waddr < 7'(RAM_WORDS)) begin
                                    d.ram[waddr[5:0]][slot[1:0]] = rx_byte[7-k];
                                end
                            end
                            // Every chip in the cascade tracks the same counters,
                            // so the one that owns the next word knows it.
                            slot = fill_slot(q.mode, 7);
                            step = 6'(slot[4:2]) + 6'h01;
                            nxt  = 7'(q.ptr) + 7'(step);
                            if (nxt >= 7'(RAM_WORDS)) begin
                                d.ptr = PTR_RST;
                                d.sub = q.sub + 3'h1;
                            end else begin
                                d.ptr = nxt[5:0];
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
        if (rst_i) begin
            d       = '0;
            d.phase = PH_IDLE;
            d.ptr   = PTR_RST;
            d.sub   = SUB_RST;
            d.mode  = MODE_RST;
            d.blink = BLINK_RST;
            d.sleep = SLEEP_RST;
        end
        d.sel = (d.phase == PH_CMD) || (d.phase == PH_DATA);
    end

    always_ff @(posedge link.scl) begin
        q <= d;
    end

    // ------------------------------------------------------------------
    // Falling-edge logic: acknowledge drive and START sampling
    // ------------------------------------------------------------------
    // The acknowledge must change only while the clock is low, otherwise
    // the master would see it as a START or STOP; hence the falling edge.
    always_comb begin
        e_d          = e_q;
        e_d.sda_n    = link.sda;
        e_d.sda_oe_n = !(q.bit_cnt == 4'h8 && q.ack);
        if (rst_i) begin
            e_d.sda_n    = 1'b1;
            e_d.sda_oe_n = 1'b1;
        end
    end

    always_ff @(negedge link.scl) begin
        e_q <= e_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.dev_sda_o    = 1'b0;
    assign link.dev_sda_oe_n = e_q.sda_oe_n;
    assign segment_outputs_o = q.ram;
    assign lcd_mode_o        = q.mode;
    assign blink_o           = q.blink;
    assign sleep_o           = q.sleep;
    assign selected_o        = q.sel;
    assign data_ptr_o        = q.ptr;
    assign subaddr_o         = q.sub;

endmodule : lcdsl_device

// ### hdl/lcdsl_host.sv
// Master end: byte buffer, bit sequencer and serial clock divider.
`timescale 1ns/1ps

module lcdsl_host #(
    parameter int unsigned QTR_CYC = lcdsl_pkg::SCL_QTR_CYC,
    parameter int unsigned WIDTH   = 9,
    parameter int unsigned DEPTH   = 2
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         tx_valid_i,
    input  wire logic [7:0]   tx_data_i,
    input  wire logic         tx_last_i,
    output logic              tx_ready_o,
    output logic              ack_valid_o,
    output logic              nack_o,
    output logic              busy_o,
    lcdsl_if.host             link
);
    import lcdsl_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
        logic                        rdy;
        lcdsl_hstate_t               st;
        logic [15:0]                 div;
        logic [1:0]                  qtr;
        logic [3:0]                  bitn;
        logic [7:0]                  sh;
        logic                        last;
        logic                        init;
        logic                        scl;
        logic                        pull;
        logic [1:0]                  sync;
        logic                        ack_valid;
        logic                        nack;
        logic                        busy;
    } lcdsl_host_state_t;

    lcdsl_host_state_t q, d;
    logic              tick;
    logic              pop;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d           = q;
        tick        = (q.div == 16'(QTR_CYC - 1));
        pop         = 1'b0;
        d.sync      = {q.sync[0], link.sda};
        d.ack_valid = 1'b0;
        d.div       = tick ? 16'h0000 : q.div + 16'h0001;
        if (tick) begin
            d.qtr = q.qtr + 2'h1;
            if (q.qtr == 2'h3) begin
                unique case (q.st)
                    H_IDLE: begin
                        d.init = 1'b0;
                        if (q.cnt != '0) begin
                            d.st = H_START;
                        end
                    end
                    H_START, H_WAIT: begin
                        if (q.cnt != '0) begin
                            pop    = 1'b1;
                            d.st   = H_BIT;
                            d.bitn = 4'h0;
                        end
                    end
                    H_BIT: begin
                        if (q.bitn == 4'h8) begin
                            d.nack      = q.sync[1];
                            d.ack_valid = !q.init;
                            if (q.last) begin
                                d.st = H_STOP;
                            end else if (q.cnt != '0) begin
                                pop    = 1'b1;
                                d.bitn = 4'h0;
                            end else begin
                                d.st = H_WAIT;
                            end
                        end else begin
                            d.sh   = {q.sh[6:0], 1'b1};
                            d.bitn = q.bitn + 4'h1;
                        end
                    end
                    H_STOP: d.st = H_IDLE;
                endcase
            end
            if (pop) begin
                {d.last, d.sh} = q.mem[q.rp];
                d.rp           = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
            end
            // Outputs for the quarter now starting. Data moves one quarter after
            // the clock falls, so the device's falling-edge sampler never sees it
            // change on that edge. Only the release for the acknowledge bit sits
            // on the fall itself, so that the device's acknowledge never overlaps
            // a data bit still driven by this end.
            unique case (d.qtr)
                2'h0: begin
                    d.scl = (d.st == H_IDLE);
                    if (d.st == H_BIT && d.bitn == 4'h8) begin
                        d.pull = 1'b0;
                    end
                end
                2'h1: begin
                    d.pull = (d.st == H_STOP)
                          || (d.st == H_BIT && d.bitn != 4'h8 && !d.sh[7]);
                end
                2'h2: d.scl = (d.st != H_WAIT);
                2'h3: d.pull = (d.st == H_START) ? 1'b1 : (d.st == H_STOP) ? 1'b0 : q.pull;
            endcase
        end
        // Two-entry buffer: source stalls on tx_ready_o until a byte is sent.
        if (tx_valid_i && q.rdy) begin
            d.mem[q.wp] = WIDTH'({tx_last_i, tx_data_i});
            d.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
        end
        d.cnt  = q.cnt + (PW+1)'(tx_valid_i && q.rdy) - (PW+1)'(pop);
        d.rdy  = (d.cnt != (PW+1)'(DEPTH));
        d.busy = (d.st != H_IDLE) || (d.cnt != '0);
        if (rst_i) begin
            // After reset nine released clocks and a STOP free a stuck bus.
            d      = '0;
            d.st   = H_BIT;
            d.sh   = 8'hff;
            d.last = 1'b1;
            d.init = 1'b1;
            d.scl  = 1'b1;
            d.sync = 2'h3;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        q <= d;
    end

    assign link.scl           = q.scl;
    assign link.host_sda_o    = 1'b0;
    assign link.host_sda_oe_n = !q.pull;
    assign tx_ready_o         = q.rdy;
    assign ack_valid_o        = q.ack_valid;
    assign nack_o             = q.nack;
    assign busy_o             = q.busy;

endmodule : lcdsl_host

// ### hdl/lcdsl_if.sv
// Two-wire link between bus master and LCD loader, with open-drain data.
`timescale 1ns/1ps

interface lcdsl_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // The data wire is pulled up; any enabled driver at zero pulls it low.
    assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;

    modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : lcdsl_if

// ### hdl/lcdsl_pkg.sv
// Shared constants and types for the LCD serial command and RAM loader.
package lcdsl_pkg;

    // ------------------------------------------------------------------
    // Addressing and display RAM geometry
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_HI    = 6'h1c;
    localparam int         RAM_WORDS  = 40;
    localparam int         COM_LINES  = 4;
    localparam int         CONT_BIT   = 7;

    // ------------------------------------------------------------------
    // Command encodings over bits 6:0, matched as (byte & mask) == code
    // ------------------------------------------------------------------
    localparam logic [6:0] CMD_PTR_MASK  = 7'h40;
    localparam logic [6:0] CMD_PTR_CODE  = 7'h00;
    localparam logic [6:0] CMD_GRP_MASK  = 7'h78;
    localparam logic [6:0] CMD_MODE_CODE = 7'h40;
    localparam logic [6:0] CMD_SLP_CODE  = 7'h48;
    localparam logic [6:0] CMD_SEL_CODE  = 7'h60;
    localparam logic [6:0] CMD_BLK_CODE  = 7'h70;

    // ------------------------------------------------------------------
    // Types and reset values
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {MODE_STATIC, MODE_DUAL, MODE_TRI, MODE_QUAD} lcdsl_mode_t;
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_DATA, PH_SKIP} lcdsl_phase_t;
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_WAIT, H_STOP} lcdsl_hstate_t;

    localparam lcdsl_mode_t MODE_RST  = MODE_QUAD;
    localparam logic [5:0]  PTR_RST   = 6'h00;
    localparam logic [2:0]  SUB_RST   = 3'h0;
    localparam logic [2:0]  BLINK_RST = 3'h0;
    localparam logic        SLEEP_RST = 1'b0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 20;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);

    function automatic logic cmd_is(input logic [7:0] b, input logic [6:0] mask,
                                    input logic [6:0] code);
        return (b[6:0] & mask) == code;
    endfunction : cmd_is

endpackage : lcdsl_pkg

// ### tb/lcdsl_monitor.sv
// Checker for the serial link between the host and device ends.
`timescale 1ns/1ps

module lcdsl_monitor #(
    parameter int unsigned QTR_CYC = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic sda
);
    localparam int Q_LO = QTR_CYC - 1;
    localparam int Q_HI = QTR_CYC + 1;
    localparam int P_LO = 4 * QTR_CYC - 2;
    localparam int P_HI = 4 * QTR_CYC + 2;

    // ------------------------------------------------------------------
    // Link timing, oversampled on the system clock
    // ------------------------------------------------------------------
    // Repeat counts of 8 assume a quarter of four system clocks.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_on;
        $fell(dev_sda_oe_n) |-> $fell(scl) ##1 (!dev_sda_oe_n)[*8];
    endproperty
    a_ack_on: assert property (p_ack_on) else $error("ack not driven from scl fall");
    property p_ack_len;
        $fell(dev_sda_oe_n) |-> ##[P_LO:P_HI] $rose(dev_sda_oe_n);
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack not one scl period");
    property p_ack_off;
        $rose(dev_sda_oe_n) |-> $fell(scl);
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("ack released off scl fall");
    property p_no_clash;
        !dev_sda_oe_n |-> host_sda_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
    property p_sda_held;
        scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe_n);
    endproperty
    a_sda_held: assert property (p_sda_held) else $error("data moved with scl high");
    property p_start;
        scl && $fell(host_sda_oe_n) |-> ##[Q_LO:Q_HI] $fell(scl);
    endproperty
    a_start: assert property (p_start) else $error("start not followed by scl low");
    property p_stop;
        scl && $rose(host_sda_oe_n) |-> (scl && sda)[*2];
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not leave bus idle");
    property p_scl_high;
        $rose(scl) |-> scl[*8];
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");

    c_ack: cover property ($fell(dev_sda_oe_n));
    c_start: cover property (scl && $fell(host_sda_oe_n));
    c_stop: cover property (scl && $rose(host_sda_oe_n));
endmodule : lcdsl_monitor

// ### tb/test_lcd_serial_cmd_ram_loader.sv
// Bench joining the host and device ends of the LCD loader over one link.
`timescale 1ns/1ps

module test_lcd_serial_cmd_ram_loader;
    import lcdsl_pkg::*;

    logic         sys_clk_i, rst_i, dev_rst, tx_valid, tx_last, tx_ready;
    logic         ack_valid, nack, busy, strap, sleep, selected, clr_acks;
    logic [7:0]   tx_data, fb[$];
    logic [2:0]   pins, blink, sub;
    logic [5:0]   ptr;
    logic [15:0]  acks;
    logic [159:0] seg, exp_ram;
    lcdsl_mode_t  mode;
    int           err_total, checks_done, n_ack, cyc;

    lcdsl_if lk ();
    lcdsl_host #(.QTR_CYC(4)) i_lcdsl_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
        .tx_ready_o(tx_ready), .ack_valid_o(ack_valid), .nack_o(nack), .busy_o(busy),
        .link(lk.host));
    lcdsl_device i_lcdsl_device (.rst_i(dev_rst), .addr_lsb_strap_i(strap),
        .chip_subaddr_bit0_i(pins[0]), .chip_subaddr_bit1_i(pins[1]),
        .chip_subaddr_bit2_i(pins[2]), .segment_outputs_o(seg), .lcd_mode_o(mode),
        .blink_o(blink), .sleep_o(sleep), .selected_o(selected), .data_ptr_o(ptr),
        .subaddr_o(sub), .link(lk.dev));
    lcdsl_monitor #(.QTR_CYC(4)) i_lcdsl_monitor (.sys_clk_i(sys_clk_i), .rst_i(dev_rst),
        .scl(lk.scl), .host_sda_o(lk.host_sda_o), .host_sda_oe_n(lk.host_sda_oe_n),
        .dev_sda_o(lk.dev_sda_o), .dev_sda_oe_n(lk.dev_sda_oe_n), .sda(lk.sda));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------------
    // Acknowledge capture and hang guard
    // ------------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (clr_acks === 1'b1) begin
            n_ack <= 0;
            acks  <= '0;
        end else if (ack_valid === 1'b1) begin
            acks[n_ack] <= nack;
            n_ack <= n_ack + 1;
        end
        if (cyc == 40000) begin
            err_total++;
            $display("Error at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    task automatic check(input logic [175:0] seen, input logic [175:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Bits go MSB first into (mode + 1) commons per word; words past the end are lost.
    function automatic void fill(input int p, input int m, input logic [7:0] b);
        for (int k = 0; k < 8; k++) begin
            if (p + k / (m + 1) < RAM_WORDS) begin
                exp_ram[4 * (p + k / (m + 1)) + k % (m + 1)] = b[7 - k];
            end
        end
    endfunction : fill

    task automatic wait_idle();
        do @(negedge sys_clk_i); while (busy !== 1'b0);
    endtask : wait_idle

    task automatic send_frame();
        clr_acks <= 1'b1;
        @(posedge sys_clk_i);
        clr_acks <= 1'b0;
        foreach (fb[i]) begin
            tx_valid <= 1'b1;
            tx_data <= fb[i];
            tx_last <= (i == fb.size() - 1);
            @(negedge sys_clk_i);
            while (tx_ready !== 1'b1) @(negedge sys_clk_i);
            @(posedge sys_clk_i);
        end
        tx_valid <= 1'b0;
        wait_idle();
        check(n_ack, fb.size());
    endtask : send_frame

    task automatic sc_modes();
        logic [7:0] p;
        for (int m = 0; m < 4; m++) begin
            p = 8'(10 * m + 1);
            fb = {8'h70, 8'hc0 | 8'(m), 8'he0, p, 8'ha5, 8'h3c};
            send_frame();
            fill(p, m, 8'ha5);
            fill(p + (8 + m) / (m + 1), m, 8'h3c);
            check(acks, 16'h0000);
            check(mode, m);
            check(ptr, p + 2 * ((8 + m) / (m + 1)));
            check(seg, exp_ram);
        end
    endtask : sc_modes

    task automatic sc_cmds();
        fb = {8'h70, 8'hf5, 8'h49};
        send_frame();
        check(acks, 16'h0000);
        check({blink, sleep}, 4'hb);
        fb = {8'h70, 8'h48};
        send_frame();
        check(sleep, 1'b0);
    endtask : sc_cmds

    task automatic sc_wrap();
        fb = {8'h70, 8'hc3, 8'he0, 8'h26, 8'h96, 8'h5a};
        send_frame();
        fill(38, 3, 8'h96);
        check(acks, 16'h0020);
        check({sub, ptr}, {3'h1, 6'h02});
        check(seg, exp_ram);
        check(selected, 1'b1);
    endtask : sc_wrap

    task automatic sc_strap();
        fb = {8'h72, 8'hc1, 8'h00};
        send_frame();
        check(acks, 16'h0007);
        check(mode, MODE_QUAD);
        check(selected, 1'b0);
        fb = {8'h71, 8'hc1, 8'h00};
        send_frame();
        check(acks, 16'h0007);
        check(selected, 1'b0);
        @(posedge sys_clk_i);
        strap <= 1'b1;
        pins <= 3'h5;
        fb = {8'h72, 8'he5, 8'h00, 8'hff};
        send_frame();
        fill(0, 3, 8'hff);
        check(acks, 16'h0000);
        fb = {8'h72, 8'he4, 8'h00, 8'h00};
        send_frame();
        check(acks, 16'h0008);
        check({sub, ptr, seg}, {3'h4, 6'h02, exp_ram});
    endtask : sc_strap

    initial begin
        rst_i = 1'b1;
        dev_rst = 1'b1;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        tx_last = 1'b0;
        clr_acks = 1'b0;
        strap = 1'b0;
        pins = 3'h0;
        exp_ram = '0;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // The device sees reset only on link clock edges, so hold it over the first four link clock rises of the bus clear.
        repeat (4) @(posedge lk.scl);
        @(posedge sys_clk_i);
        dev_rst <= 1'b0;
        wait_idle();
        check({mode, ptr, sub, blink, sleep, seg},
              {MODE_RST, PTR_RST, SUB_RST, BLINK_RST, SLEEP_RST, 160'h0});
        sc_modes();
        sc_cmds();
        sc_wrap();
        sc_strap();
        give_verdict();
    end
endmodule : test_lcd_serial_cmd_ram_loader
